// >>> imcc_defines.svh
`ifndef IMCC_DEFINES_SVH
`define IMCC_DEFINES_SVH
// register byte addresses
`define IMCC_ADDR_ROUTE 8'h60
`define IMCC_ADDR_CAL 8'h61
`define IMCC_ADDR_PUMP 8'h4F
// reset values
`define IMCC_RST_ROUTE 8'h01
`define IMCC_RST_CAL 8'h01
`define IMCC_RST_PUMP 8'h0B
// field positions
`define IMCC_SWAP_BIT 4
`define IMCC_SRC_LSB 0
`define IMCC_SRC_MSB 1
`define IMCC_CAL_BIT 0
`define IMCC_PUMP_LSB 0
`define IMCC_PUMP_MSB 2
// source select codes
`define IMCC_SRC_RSVD 2'h0
`define IMCC_SRC_A 2'h1
`define IMCC_SRC_B 2'h2
`define IMCC_SRC_DES 2'h3
// pump code that means nominal current
`define IMCC_PUMP_NOMINAL 3'h3
`endif

// >>> imcc_pkg.sv
package imcc_pkg;
   typedef logic [7:0] imcc_byte_t;
   // which input pair feeds a converter channel
   typedef enum logic [1:0] {
      IMCC_PAIR_NONE = 2'h0,
      IMCC_PAIR_A = 2'h1,
      IMCC_PAIR_B = 2'h2
   } imcc_pair_e;
   // calibration sequencer, gray along hold -> run -> settled
   typedef enum logic [1:0] {
      IMCC_CAL_HOLD = 2'h0,
      IMCC_CAL_RUN = 2'h1,
      IMCC_CAL_DONE = 2'h3
   } imcc_cal_e;
endpackage : imcc_pkg

// >>> imcc_route_if.sv
`timescale 1ns/100ps
interface imcc_route_if;
   logic single_mode;
   logic swap;
   logic [1:0] source;
   imcc_pkg::imcc_pair_e pair_a;
   imcc_pkg::imcc_pair_e pair_b;
   modport ctrl (output single_mode, output swap, output source,
      input pair_a, input pair_b);
   modport decode (input single_mode, input swap, input source,
      output pair_a, output pair_b);
endinterface : imcc_route_if

// >>> imcc_route_decode.sv
`timescale 1ns/100ps
`include "imcc_defines.svh"
module imcc_route_decode (
   imcc_route_if.decode rt
);
   always_comb begin
      rt.pair_a = imcc_pkg::IMCC_PAIR_A;
      rt.pair_b = imcc_pkg::IMCC_PAIR_B;
      if (rt.single_mode) begin
         // swap bit ignored here
         unique case (rt.source)
            `IMCC_SRC_RSVD: begin
               rt.pair_a = imcc_pkg::IMCC_PAIR_NONE;
               rt.pair_b = imcc_pkg::IMCC_PAIR_NONE;
            end
            `IMCC_SRC_A: begin
               rt.pair_a = imcc_pkg::IMCC_PAIR_A;
               rt.pair_b = imcc_pkg::IMCC_PAIR_A;
            end
            `IMCC_SRC_B: begin
               rt.pair_a = imcc_pkg::IMCC_PAIR_B;
               rt.pair_b = imcc_pkg::IMCC_PAIR_B;
            end
            `IMCC_SRC_DES: begin
               rt.pair_a = imcc_pkg::IMCC_PAIR_A;
               rt.pair_b = imcc_pkg::IMCC_PAIR_B;
            end
         endcase
      end else if (rt.swap) begin
         // source select ignored in dual modes
         rt.pair_a = imcc_pkg::IMCC_PAIR_B;
         rt.pair_b = imcc_pkg::IMCC_PAIR_A;
      end
   end
endmodule : imcc_route_decode

// >>> imcc_ctrl.sv
// Functional notes
// - the 3-bit pump trim scales charge-pump current from -70% to +100%, code 3 nominal and default.
// - in dual modes the swap bit exchanges which input pair each channel samples.
// - the swap bit does nothing while a single-channel link mode is chosen.
// - the source select picks reserved, pair A, pair B, or A/B interleaved, default pair A.
// - the source select does nothing while a dual-channel link mode is chosen.
// - a new input route takes effect only when a calibration run starts after the change.
// - calibration runs while the run bit is 1 and is held in reset at 0; reset value 1.
// - clearing the run bit also resets the digital and link clock dividers.
// - setting the run bit again reruns calibration with the new settings.
`timescale 1ns/100ps
`include "imcc_defines.svh"
module imcc_ctrl #(
   parameter int CAL_CYCLES = 16
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // register port
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // device context
   input wire logic link_mode_single_in,
   input wire logic link_output_enable_in,
   // calibration engine, dividers, pump trim and input route
   output logic cal_reset_n_out,
   output logic cal_busy_out,
   output logic divider_reset_n_out,
   output logic [2:0] loop_pump_current_trim_out,
   output logic [1:0] route_a_out,
   output logic [1:0] route_b_out
);
   // ***************************************************
   // registers
   // ***************************************************
   imcc_pkg::imcc_byte_t input_route_control;
   imcc_pkg::imcc_byte_t calibration_run_control;
   imcc_pkg::imcc_byte_t pll_pump_trim_control;
   imcc_pkg::imcc_byte_t next_input_route_control;
   imcc_pkg::imcc_byte_t next_calibration_run_control;
   imcc_pkg::imcc_byte_t next_pll_pump_trim_control;
   logic [7:0] next_reg_rdata;
   logic [2:0] addr_sel;

   // one decode feeds both the write and the read path, so a register
   // cannot end up writable but not readable
   function automatic logic [2:0] reg_select(input logic [7:0] addr);
      logic [2:0] sel;
      sel = 3'h0;
      unique case (addr)
         `IMCC_ADDR_ROUTE: sel = 3'h1;
         `IMCC_ADDR_CAL: sel = 3'h2;
         `IMCC_ADDR_PUMP: sel = 3'h4;
         default: sel = 3'h0;
      endcase
      return sel;
   endfunction : reg_select

   assign addr_sel = reg_select(reg_addr_in);

   // ***************************************************
   // register write
   // ***************************************************
   always_comb begin
      next_input_route_control = input_route_control;
      next_calibration_run_control = calibration_run_control;
      next_pll_pump_trim_control = pll_pump_trim_control;
      if (reg_wr_in) begin
         // reserved bits are stored as written; unmapped writes drop
         if (addr_sel[0]) begin
            next_input_route_control = reg_wdata_in;
         end
         if (addr_sel[1]) begin
            next_calibration_run_control = reg_wdata_in;
         end
         if (addr_sel[2]) begin
            next_pll_pump_trim_control = reg_wdata_in;
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         input_route_control <= `IMCC_RST_ROUTE;
         calibration_run_control <= `IMCC_RST_CAL;
         pll_pump_trim_control <= `IMCC_RST_PUMP;
      end else begin
         input_route_control <= next_input_route_control;
         calibration_run_control <= next_calibration_run_control;
         pll_pump_trim_control <= next_pll_pump_trim_control;
      end
   end

   // ***************************************************
   // register read
   // ***************************************************
   // a read in the same cycle as a write to that register returns the
   // old contents; the data then stands until the next read
   always_comb begin
      next_reg_rdata = reg_rdata_out;
      if (reg_rd_in) begin
         unique case (addr_sel)
            3'h1: next_reg_rdata = input_route_control;
            3'h2: next_reg_rdata = calibration_run_control;
            3'h4: next_reg_rdata = pll_pump_trim_control;
            default: next_reg_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         reg_rdata_out <= next_reg_rdata;
      end
   end

   logic cal_run;
   assign cal_run = calibration_run_control[`IMCC_CAL_BIT];

   // ***************************************************
   // route decode
   // ***************************************************
   // the decoded route follows the register live, but only reaches the
   // outputs when a calibration starts
   imcc_route_if rt ();
   assign rt.single_mode = link_mode_single_in;
   assign rt.swap = input_route_control[`IMCC_SWAP_BIT];
   assign rt.source = input_route_control[`IMCC_SRC_MSB:`IMCC_SRC_LSB];

   imcc_route_decode u_decode (
      .rt(rt.decode)
   );

   // ***************************************************
   // calibration sequencer
   // ***************************************************
   // the route is latched at calibration start so a mux change waits
   // for the next calibration rather than glitching live data
   localparam int CW = $clog2(CAL_CYCLES + 1);
   imcc_pkg::imcc_cal_e cal_state;
   imcc_pkg::imcc_cal_e next_cal_state;
   logic [CW-1:0] cal_count;
   logic [CW-1:0] next_cal_count;
   logic [1:0] next_route_a;
   logic [1:0] next_route_b;
   logic [2:0] next_trim;
   logic next_cal_reset_n;
   logic next_divider_reset_n;
   logic next_cal_busy;

   always_comb begin
      next_cal_state = cal_state;
      next_cal_count = cal_count;
      next_route_a = route_a_out;
      next_route_b = route_b_out;
      next_trim =
         pll_pump_trim_control[`IMCC_PUMP_MSB:`IMCC_PUMP_LSB];
      next_cal_reset_n = cal_run;
      // dividers share the hold with the calibration engine; the order
      // against the link enable is the host's duty and cannot be refused
      // here, so the link enable input is left unread
      next_divider_reset_n = cal_run;
      if (!cal_run) begin
         next_cal_state = imcc_pkg::IMCC_CAL_HOLD;
         next_cal_count = '0;
      end else begin
         unique case (cal_state)
            imcc_pkg::IMCC_CAL_HOLD: begin
               // input route loaded on rerun
               next_cal_state = imcc_pkg::IMCC_CAL_RUN;
               next_cal_count = '0;
               next_route_a = rt.pair_a;
               next_route_b = rt.pair_b;
            end
            imcc_pkg::IMCC_CAL_RUN: begin
               next_cal_count = cal_count + CW'(1);
               if (cal_count == CW'(CAL_CYCLES - 1)) begin
                  next_cal_state = imcc_pkg::IMCC_CAL_DONE;
               end
            end
            imcc_pkg::IMCC_CAL_DONE: begin
               // stays here until the host drops the run bit; a rerun
               // needs a clear and then a set
            end
            default: next_cal_state = imcc_pkg::IMCC_CAL_HOLD;
         endcase
      end
      next_cal_busy = (next_cal_state == imcc_pkg::IMCC_CAL_RUN);
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cal_state <= imcc_pkg::IMCC_CAL_HOLD;
         cal_count <= '0;
         route_a_out <= imcc_pkg::IMCC_PAIR_A;
         route_b_out <= imcc_pkg::IMCC_PAIR_B;
         loop_pump_current_trim_out <= `IMCC_PUMP_NOMINAL;
         cal_reset_n_out <= 1'b0;
         divider_reset_n_out <= 1'b0;
         cal_busy_out <= 1'b0;
      end else begin
         cal_state <= next_cal_state;
         cal_count <= next_cal_count;
         route_a_out <= next_route_a;
         route_b_out <= next_route_b;
         loop_pump_current_trim_out <= next_trim;
         cal_reset_n_out <= next_cal_reset_n;
         divider_reset_n_out <= next_divider_reset_n;
         cal_busy_out <= next_cal_busy;
      end
   end
endmodule : imcc_ctrl

// >>> imcc_ctrl_chk.sv
`timescale 1ns/100ps
// ****
// properties of the register port and calibration outputs
// ****
module imcc_ctrl_chk #(
   parameter int CAL_CYCLES = 16
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic cal_reset_n_out,
   input wire logic cal_busy_out,
   input wire logic divider_reset_n_out,
   input wire logic [2:0] loop_pump_current_trim_out,
   input wire logic [1:0] route_a_out,
   input wire logic [1:0] route_b_out
);
   int busy_cnt;
   int next_busy_cnt;
   always_comb next_busy_cnt = cal_busy_out ? busy_cnt + 1 : 0;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) busy_cnt <= 0;
      else busy_cnt <= next_busy_cnt;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   AST_TRIM_WR: assert property (
      reg_wr_in && reg_addr_in == 8'h4F ##1 !reg_wr_in
      |=> loop_pump_current_trim_out == $past(reg_wdata_in[2:0], 2))
      else $error("pump trim output differs from written code");
   AST_RD_CAL: assert property (
      reg_rd_in && reg_addr_in == 8'h61
      |=> reg_rdata_out[0] == cal_reset_n_out)
      else $error("run bit read back differs from calibration reset");
   AST_HOLD_IDLE: assert property (
      !cal_reset_n_out |-> !cal_busy_out)
      else $error("calibration busy while held in reset");
   AST_DIV_TIED: assert property (
      divider_reset_n_out == cal_reset_n_out)
      else $error("divider reset not following run bit");
   AST_CAL_CLR: assert property (
      reg_wr_in && reg_addr_in == 8'h61 && !reg_wdata_in[0]
      |-> ##2 !cal_reset_n_out && !divider_reset_n_out)
      else $error("clearing run bit did not hold calibration");
   AST_CAL_SET: assert property (
      reg_wr_in && reg_addr_in == 8'h61 && reg_wdata_in[0]
      |-> ##2 cal_reset_n_out && divider_reset_n_out)
      else $error("setting run bit did not release calibration");
   AST_BUSY_LEN: assert property (
      $fell(cal_busy_out) && cal_reset_n_out |-> busy_cnt == CAL_CYCLES)
      else $error("calibration run length wrong");
   AST_BUSY_MAX: assert property (
      cal_busy_out |-> busy_cnt < CAL_CYCLES)
      else $error("calibration run too long");
   AST_BUSY_START: assert property (
      $rose(cal_reset_n_out) |-> cal_busy_out)
      else $error("calibration did not start on release");
   AST_ROUTE_HOLD: assert property (
      $changed({route_a_out, route_b_out}) |-> $rose(cal_busy_out))
      else $error("input route changed outside calibration start");
   cover property ($fell(cal_busy_out));
   cover property ($changed(route_a_out));
   cover property (reg_rd_in && reg_addr_in == 8'h4F);
endmodule : imcc_ctrl_chk

// >>> imcc_ctrl_test.sv
`timescale 1ns/100ps
// ****
// directed regression of the control slice
// ****
module imcc_ctrl_test;
   localparam int CALC = 2;
   logic clk_in, arst_n_in, reg_wr_in, reg_rd_in, link_mode_single_in;
   logic link_output_enable_in, cal_reset_n_out, cal_busy_out;
   logic divider_reset_n_out;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic [2:0] loop_pump_current_trim_out;
   logic [1:0] route_a_out, route_b_out;
   logic [3:0] prev;
   int bad_count = 0;
   int total_checks = 0;
   // single flag, route register, expected pair on channel a and b
   logic [15:0] rows [8] = '{16'h0006, 16'h0109, 16'h0129, 16'h1015,
      16'h102A, 16'h1036, 16'h1000, 16'h1115};
   imcc_ctrl #(.CAL_CYCLES(CALC)) i_dut (.clk_in(clk_in),
      .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .link_mode_single_in(link_mode_single_in),
      .link_output_enable_in(link_output_enable_in),
      .cal_reset_n_out(cal_reset_n_out), .cal_busy_out(cal_busy_out),
      .divider_reset_n_out(divider_reset_n_out),
      .loop_pump_current_trim_out(loop_pump_current_trim_out),
      .route_a_out(route_a_out), .route_b_out(route_b_out));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      reg_wr_in = 1'b1;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_in);
      reg_rd_in = 1'b1;
      reg_addr_in = a;
      @(negedge clk_in);
      reg_rd_in = 1'b0;
      chk(reg_rdata_out, e);
   endtask : rd
   task automatic cal_run;
      link_output_enable_in = 1'b0;
      wr(8'h61, 8'h00);
      repeat (2) @(negedge clk_in);
      chk({6'h00, cal_reset_n_out, divider_reset_n_out}, 8'h00);
      wr(8'h61, 8'h01);
      repeat (2) @(negedge clk_in);
      chk({7'h00, cal_busy_out}, 8'h01);
      chk({6'h00, cal_reset_n_out, divider_reset_n_out}, 8'h03);
      repeat (CALC + 2) @(negedge clk_in);
      chk({7'h00, cal_busy_out}, 8'h00);
      link_output_enable_in = 1'b1;
   endtask : cal_run
   task automatic do_reset;
      arst_n_in = 1'b0;
      repeat (12) @(negedge clk_in);
      arst_n_in = 1'b1;
      chk({1'b0, loop_pump_current_trim_out, route_a_out, route_b_out},
         8'h36);
      rd(8'h60, 8'h01);
      rd(8'h61, 8'h01);
      rd(8'h4F, 8'h0B);
   endtask : do_reset
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // the whole run needs well under a thousand cycles
   initial begin
      #200000;
      bad_count++;
      give_verdict;
   end
   initial begin
      {reg_wr_in, reg_rd_in, link_mode_single_in} = 3'h0;
      link_output_enable_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      do_reset;
      prev = 4'h6;
      foreach (rows[i]) begin
         link_mode_single_in = rows[i][12];
         wr(8'h60, rows[i][11:4]);
         chk({4'h0, route_a_out, route_b_out}, {4'h0, prev});
         rd(8'h60, rows[i][11:4]);
         cal_run;
         chk({4'h0, route_a_out, route_b_out},
            {4'h0, rows[i][3:0]});
         prev = rows[i][3:0];
      end
      for (int c = 0; c < 8; c++) begin
         wr(8'h4F, {5'h1F, c[2:0]});
         rd(8'h4F, {5'h1F, c[2:0]});
         chk({5'h00, loop_pump_current_trim_out},
            {5'h00, c[2:0]});
      end
      wr(8'h70, 8'hA5);
      rd(8'h70, 8'h00);
      wr(8'h61, 8'hFF);
      rd(8'h61, 8'hFF);
      // second reset lands in the middle of a calibration run
      link_output_enable_in = 1'b0;
      wr(8'h61, 8'h00);
      wr(8'h61, 8'h01);
      repeat (2) @(negedge clk_in);
      do_reset;
      give_verdict;
   end
endmodule : imcc_ctrl_test
bind imcc_ctrl imcc_ctrl_chk #(.CAL_CYCLES(CAL_CYCLES)) i_chk (.clk_in(clk_in),
   .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .cal_reset_n_out(cal_reset_n_out),
   .cal_busy_out(cal_busy_out), .divider_reset_n_out(divider_reset_n_out),
   .loop_pump_current_trim_out(loop_pump_current_trim_out),
   .route_a_out(route_a_out), .route_b_out(route_b_out));
